//--- rtl/bct_consts.svh
`ifndef BCT_CONSTS_SVH
`define BCT_CONSTS_SVH

// Auxiliary control field positions
`define BCT_AUX_MODE_BIT 6
`define BCT_AUX_SRC_HI 5
`define BCT_AUX_SRC_LO 4

// Divider clock source codes
`define BCT_SRC_EXT 2'h0
`define BCT_SRC_EXT16 2'h1
`define BCT_SRC_OSC 2'h2
`define BCT_SRC_OSC16 2'h3

// Channel command codes for receive time-out
`define BCT_CMD_TO_ON 4'ha
`define BCT_CMD_TO_OFF 4'hc

// Extended mode bit enabling the extra rates
`define BCT_EXT_RATE_BIT 0

// Counter reset value and full count
`define BCT_CNT_RST 16'h0000
`define BCT_CNT_MAX 16'hffff

// Oscillator ticks per 16x baud clock
`define BCT_DIV_50 13'h1200
`define BCT_DIV_75 13'h0c00
`define BCT_DIV_110 13'h082f
`define BCT_DIV_150 13'h0600
`define BCT_DIV_300 13'h0300
`define BCT_DIV_600 13'h0180
`define BCT_DIV_1200 13'h00c0
`define BCT_DIV_2400 13'h0060
`define BCT_DIV_4800 13'h0030
`define BCT_DIV_9600 13'h0018
`define BCT_DIV_19200 13'h000c
`define BCT_DIV_38400 13'h0006
`define BCT_DIV_57600 13'h0004
`define BCT_DIV_115200 13'h0002
`define BCT_DIV_230400 13'h0001
`define BCT_DIV_NONE 13'h0000

`endif

//--- rtl/bct_pkg.sv
package bct_pkg;

	// Source of one receiver or transmitter clock
	typedef enum logic [1:0] {
		BCT_SEL_GEN = 2'h0,
		BCT_SEL_DIV = 2'h1,
		BCT_SEL_EXT16 = 2'h2,
		BCT_SEL_EXT1 = 2'h3
	} bct_src_type;

	// One clock selector setting
	typedef struct packed {
		bct_src_type src;
		logic [3:0] rate;
	} bct_sel_type;

	// Channel command strobe with its code
	typedef struct packed {
		logic wr;
		logic [3:0] code;
	} bct_cmd_type;

endpackage : bct_pkg

//--- rtl/bct_top.sv
`timescale 1ns/10ps
`include "bct_consts.svh"

module bct_top (
	input wire logic sys_clk, // System clock, 100 MHz
	input wire logic rst, // Asynchronous reset, active high
	input wire logic osc_input, // Oscillator reference pin
	input wire logic ctr_ext_in, // Divider external clock pin
	input wire logic [3:0] ext_timing_in, // External clocks per selector
	input wire logic [7:0] divisor_low_reg, // Divisor low byte
	input wire logic [7:0] divisor_high_reg, // Divisor high byte
	input wire logic [6:4] aux_control_reg, // Divider mode and source
	input wire logic [2:0] extended_mode_reg_chan_a, // Channel A ext mode
	input wire logic start_cmd, // Start read strobe, one cycle
	input wire logic stop_cmd, // Stop read strobe, one cycle
	input wire bct_pkg::bct_cmd_type command_reg_chan_a, // Channel A command
	input wire bct_pkg::bct_cmd_type command_reg_chan_b, // Channel B command
	input wire logic rx_char_a, // Channel A char into FIFO, pulse
	input wire logic rx_char_b, // Channel B char into FIFO, pulse
	input wire bct_pkg::bct_sel_type [3:0] clock_select_reg, // Selectors
	input wire logic ct_on_pin, // Route divider to the output pin
	input wire logic gp_level, // Pin level when not routed
	output logic [7:0] count_low_read, // Live count, low byte
	output logic [7:0] count_high_read, // Live count, high byte
	output logic ready_flag, // Ready bit of irq status
	output logic div_out, // Divider output level
	output logic timeout_active, // Time-out mode on
	output logic general_output_pins, // Pin carrying divider output
	output logic [3:0] baud_tick, // 16x or 1x clock enables: RxA TxA RxB TxB
	output logic [3:0] baud_x16 // Selector runs in 16x mode
);

	// Pin synchronisers for oscillator, divider pin and externals
	logic [5:0] pins;
	logic [5:0] s1_ff;
	logic [5:0] s2_ff;
	logic [5:0] s3_ff;
	logic [5:0] lvl_ff;
	logic [5:0] agree;
	logic [5:0] nxt_lvl;
	logic [5:0] rise;

	assign pins = {ext_timing_in, ctr_ext_in, osc_input};
	assign agree = ~(s2_ff ^ s3_ff);
	assign nxt_lvl = (agree & s3_ff) | (~agree & lvl_ff);
	assign rise = nxt_lvl & ~lvl_ff;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s1_ff <= 6'h00;
			s2_ff <= 6'h00;
			s3_ff <= 6'h00;
			lvl_ff <= 6'h00;
		end else begin
			s1_ff <= pins;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			lvl_ff <= nxt_lvl;
		end
	end

	// Edge enables derived from the synchronised pins
	logic osc_tick;
	logic ext_tick;
	logic [3:0] sel_ext_tick;
	assign osc_tick = rise[0];
	assign ext_tick = rise[1];
	assign sel_ext_tick = rise[5:2];

	// Divide-by-16 prescalers for the divider source
	logic [3:0] osc_pre_ff;
	logic [3:0] ext_pre_ff;
	logic osc16_tick;
	logic ext16_tick;
	assign osc16_tick = osc_tick & (osc_pre_ff == 4'hf);
	assign ext16_tick = ext_tick & (ext_pre_ff == 4'hf);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			osc_pre_ff <= 4'h0;
			ext_pre_ff <= 4'h0;
		end else begin
			osc_pre_ff <= osc_pre_ff + {3'h0, osc_tick};
			ext_pre_ff <= ext_pre_ff + {3'h0, ext_tick};
		end
	end

	// Divider clock source and mode select
	logic to_a_ff;
	logic to_b_ff;
	logic [1:0] ct_src;
	logic ct_tick;
	logic to_any;
	logic timer_mode;
	assign ct_src = aux_control_reg[`BCT_AUX_SRC_HI:`BCT_AUX_SRC_LO];
	assign ct_tick = (ct_src == `BCT_SRC_EXT) ? ext_tick :
		(ct_src == `BCT_SRC_EXT16) ? ext16_tick :
		(ct_src == `BCT_SRC_OSC) ? osc_tick : osc16_tick;
	assign to_any = to_a_ff | to_b_ff;
	assign timer_mode = aux_control_reg[`BCT_AUX_MODE_BIT] & ~to_any;

	// Time-out command decode per channel
	logic on_a;
	logic off_a;
	logic on_b;
	logic off_b;
	logic to_on;
	logic rx_any;
	assign on_a = command_reg_chan_a.wr &
		(command_reg_chan_a.code == `BCT_CMD_TO_ON);
	assign off_a = command_reg_chan_a.wr &
		(command_reg_chan_a.code == `BCT_CMD_TO_OFF);
	assign on_b = command_reg_chan_b.wr &
		(command_reg_chan_b.code == `BCT_CMD_TO_ON);
	assign off_b = command_reg_chan_b.wr &
		(command_reg_chan_b.code == `BCT_CMD_TO_OFF);
	assign to_on = on_a | on_b;
	assign rx_any = (rx_char_a & to_a_ff) | (rx_char_b & to_b_ff);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			to_a_ff <= 1'b0;
			to_b_ff <= 1'b0;
		end else begin
			to_a_ff <= on_a | (to_a_ff & ~off_a);
			to_b_ff <= on_b | (to_b_ff & ~off_b);
		end
	end

	// Divider counting engine
	logic [15:0] divisor;
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	logic out_ff;
	logic nxt_out;
	logic run_ff;
	logic nxt_run;
	assign divisor = {divisor_high_reg, divisor_low_reg};

	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_out = out_ff;
		nxt_run = run_ff;
		if (to_any) begin
			// Received data drives the count; start and stop ignored
			if (to_on) begin
				nxt_run = 1'b0;
			end else if (rx_any) begin
				nxt_cnt = divisor;
				nxt_run = 1'b1;
				nxt_out = 1'b1;
			end else if (run_ff & ct_tick) begin
				nxt_cnt = cnt_ff - 16'h0001;
				if (cnt_ff == 16'h0001) begin
					nxt_run = 1'b0;
					nxt_out = 1'b0;
				end
			end
		end else if (timer_mode) begin
			// Free running square wave, reload at each half period
			if (start_cmd) begin
				nxt_cnt = divisor;
			end else if (ct_tick) begin
				if (cnt_ff <= 16'h0001) begin
					nxt_cnt = divisor;
					nxt_out = ~out_ff;
				end else begin
					nxt_cnt = cnt_ff - 16'h0001;
				end
			end
		end else begin
			// One-shot delay, wraps past zero and keeps counting
			if (start_cmd) begin
				nxt_cnt = divisor;
				nxt_run = 1'b1;
				nxt_out = 1'b1;
			end else if (stop_cmd) begin
				nxt_run = 1'b0;
			end else if (run_ff & ct_tick) begin
				nxt_cnt = cnt_ff - 16'h0001;
				if (cnt_ff == 16'h0001) begin
					nxt_out = 1'b0;
				end
			end
		end
	end

	// Ready flag: a falling output wins over any clear
	logic fall;
	logic ready_clr;
	logic nxt_ready;
	logic ready_ff;
	assign fall = out_ff & ~nxt_out;
	assign ready_clr = (stop_cmd & ~to_any) | to_on | rx_any;
	assign nxt_ready = fall | (ready_ff & ~ready_clr);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= `BCT_CNT_RST;
			out_ff <= 1'b1;
			run_ff <= 1'b0;
			ready_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			out_ff <= nxt_out;
			run_ff <= nxt_run;
			ready_ff <= nxt_ready;
		end
	end

	// Live count and flag straight from the registers
	assign count_low_read = cnt_ff[7:0];
	assign count_high_read = cnt_ff[15:8];
	assign ready_flag = ready_ff;
	assign div_out = out_ff;

	// Divider rising edge is one 16x period
	logic div_rise;
	assign div_rise = ~out_ff & nxt_out;

	// Rate table, extended entries gated by channel A bit
	logic ext_rate;
	assign ext_rate = extended_mode_reg_chan_a[`BCT_EXT_RATE_BIT];

	function automatic logic [12:0] rate_div(input logic [3:0] code,
		input logic ext_en);
		logic [12:0] d;
		d = `BCT_DIV_NONE;
		unique case (code)
			4'h0: d = `BCT_DIV_50;
			4'h1: d = `BCT_DIV_75;
			4'h2: d = `BCT_DIV_110;
			4'h3: d = `BCT_DIV_150;
			4'h4: d = `BCT_DIV_300;
			4'h5: d = `BCT_DIV_600;
			4'h6: d = `BCT_DIV_1200;
			4'h7: d = `BCT_DIV_2400;
			4'h8: d = `BCT_DIV_4800;
			4'h9: d = `BCT_DIV_9600;
			4'ha: d = `BCT_DIV_19200;
			4'hb: d = `BCT_DIV_38400;
			4'hc: d = ext_en ? `BCT_DIV_57600 : `BCT_DIV_NONE;
			4'hd: d = ext_en ? `BCT_DIV_115200 : `BCT_DIV_NONE;
			4'he: d = ext_en ? `BCT_DIV_230400 : `BCT_DIV_NONE;
			4'hf: d = `BCT_DIV_NONE;
		endcase
		return d;
	endfunction : rate_div

	// Four selectors, each with its own generator divider
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sel
			logic [12:0] gdiv;
			logic [12:0] gcnt_ff;
			logic gen_tick;
			logic sel_tick;
			logic sel_x16;
			bct_pkg::bct_sel_type cfg;
			assign cfg = clock_select_reg[gi];
			assign gdiv = rate_div(cfg.rate, ext_rate);
			assign gen_tick = osc_tick & (gdiv != `BCT_DIV_NONE) &
				(gcnt_ff >= gdiv - 13'h0001);
			assign sel_tick = (cfg.src == bct_pkg::BCT_SEL_GEN) ? gen_tick :
				(cfg.src == bct_pkg::BCT_SEL_DIV) ? div_rise :
				sel_ext_tick[gi];
			assign sel_x16 = (cfg.src != bct_pkg::BCT_SEL_EXT1);

			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					gcnt_ff <= 13'h0000;
					baud_tick[gi] <= 1'b0;
					baud_x16[gi] <= 1'b1;
				end else begin
					if (gen_tick) begin
						gcnt_ff <= 13'h0000;
					end else if (osc_tick) begin
						gcnt_ff <= gcnt_ff + 13'h0001;
					end
					baud_tick[gi] <= sel_tick;
					baud_x16[gi] <= sel_x16;
				end
			end
		end
	endgenerate

	// Divider output onto the general output pin
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			general_output_pins <= 1'b1;
			timeout_active <= 1'b0;
		end else begin
			general_output_pins <= ct_on_pin ? out_ff : gp_level;
			timeout_active <= to_any;
		end
	end

endmodule : bct_top

//--- verification/bct_osc_model.sv
`timescale 1ns/10ps
// Free-running oscillator standing in for the reference clock source
module bct_osc_model #(
	parameter int HALF_NS = 40 // Half period in ns
) (
	output logic osc // Oscillator pin
);
	// Offset from the system clock edges, then toggle forever
	initial begin
		osc = 1'b0;
		#3;
		forever #(HALF_NS) osc = ~osc;
	end
endmodule : bct_osc_model

//--- verification/bct_top_assertions.sv
`timescale 1ns/10ps
module bct_top_assertions (
	input wire logic sys_clk, // Clock
	input wire logic rst, // Reset
	input wire logic [7:0] divisor_low_reg, // Low byte
	input wire logic [7:0] divisor_high_reg, // High byte
	input wire logic [6:4] aux_control_reg, // Mode
	input wire logic start_cmd, // Start
	input wire logic stop_cmd, // Stop
	input wire bct_pkg::bct_sel_type [3:0] clock_select_reg, // Selectors
	input wire logic ct_on_pin, // Routing
	input wire logic [7:0] count_low_read, // Count low
	input wire logic [7:0] count_high_read, // Count high
	input wire logic ready_flag, // Ready
	input wire logic div_out, // Output
	input wire logic timeout_active, // Time-out on
	input wire logic general_output_pins, // Pin
	input wire logic [3:0] baud_x16 // 16x flags
);
	// Joined count, divisor and expected 16x flags
	logic [15:0] cnt;
	logic [15:0] div_val;
	logic [3:0] x16_exp;
	assign cnt = {count_high_read, count_low_read};
	assign div_val = {divisor_high_reg, divisor_low_reg};
	assign x16_exp[0] = clock_select_reg[0].src != bct_pkg::BCT_SEL_EXT1;
	assign x16_exp[1] = clock_select_reg[1].src != bct_pkg::BCT_SEL_EXT1;
	assign x16_exp[2] = clock_select_reg[2].src != bct_pkg::BCT_SEL_EXT1;
	assign x16_exp[3] = clock_select_reg[3].src != bct_pkg::BCT_SEL_EXT1;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	chk_start_load: assert property (
		start_cmd && !timeout_active |=> cnt == $past(div_val))
		else $error("count not loaded by start");
	chk_start_high: assert property (
		start_cmd && !timeout_active && !aux_control_reg[6] |=> div_out)
		else $error("output not high after start");
	chk_stop_clear: assert property (
		stop_cmd && !start_cmd && !timeout_active |=> !ready_flag)
		else $error("ready not cleared by stop");
	chk_fall_ready: assert property (
		$fell(div_out) |-> ready_flag)
		else $error("ready missing on output fall");
	chk_ready_cause: assert property (
		$rose(ready_flag) |-> !div_out && $past(div_out))
		else $error("ready set without output fall");
	chk_count_zero: assert property (
		!aux_control_reg[6] && !timeout_active && $fell(div_out)
		|-> cnt == 16'h0000)
		else $error("counter output fell away from zero");
	chk_pin_route: assert property (
		ct_on_pin |=> general_output_pins == $past(div_out))
		else $error("pin does not follow divider");
	chk_x16_mode: assert property (
		##1 baud_x16 == $past(x16_exp))
		else $error("16x flags wrong");
endmodule : bct_top_assertions

bind bct_top bct_top_assertions u_chk (
	.sys_clk(sys_clk), .rst(rst), .divisor_low_reg(divisor_low_reg),
	.divisor_high_reg(divisor_high_reg), .aux_control_reg(aux_control_reg),
	.start_cmd(start_cmd), .stop_cmd(stop_cmd),
	.clock_select_reg(clock_select_reg), .ct_on_pin(ct_on_pin),
	.count_low_read(count_low_read), .count_high_read(count_high_read),
	.ready_flag(ready_flag), .div_out(div_out),
	.timeout_active(timeout_active),
	.general_output_pins(general_output_pins), .baud_x16(baud_x16)
);

//--- verification/testbench.sv
`timescale 1ns/10ps
module testbench;
	logic sys_clk = 1'b0, rst = 1'b1, ctr_ext_in = 1'b0, gp_level = 1'b0;
	logic start_cmd = 1'b0, stop_cmd = 1'b0, ct_on_pin = 1'b0;
	logic rx_char_a = 1'b0, rx_char_b = 1'b0, osc_input;
	logic [3:0] ext_timing_in = 4'h0;
	logic [7:0] divisor_low_reg = 8'h00, divisor_high_reg = 8'h00;
	logic [6:4] aux_control_reg = 3'h2;
	logic [2:0] extended_mode_reg_chan_a = 3'h0;
	bct_pkg::bct_cmd_type command_reg_chan_a = 5'h00;
	bct_pkg::bct_cmd_type command_reg_chan_b = 5'h00;
	bct_pkg::bct_sel_type [3:0] clock_select_reg = 24'h000000;
	logic [7:0] count_low_read, count_high_read;
	logic ready_flag, div_out, timeout_active, general_output_pins;
	logic [3:0] baud_tick, baud_x16;
	logic [15:0] cnt, d;
	logic pre;
	int mismatches = 0, checks_done = 0, n;
	assign cnt = {count_high_read, count_low_read};

	bct_osc_model u_osc (.osc(osc_input));
	bct_top dut (.sys_clk(sys_clk), .rst(rst), .osc_input(osc_input),
		.ctr_ext_in(ctr_ext_in), .ext_timing_in(ext_timing_in),
		.divisor_low_reg(divisor_low_reg), .divisor_high_reg(divisor_high_reg),
		.aux_control_reg(aux_control_reg),
		.extended_mode_reg_chan_a(extended_mode_reg_chan_a),
		.start_cmd(start_cmd), .stop_cmd(stop_cmd),
		.command_reg_chan_a(command_reg_chan_a),
		.command_reg_chan_b(command_reg_chan_b), .rx_char_a(rx_char_a),
		.rx_char_b(rx_char_b), .clock_select_reg(clock_select_reg),
		.ct_on_pin(ct_on_pin), .gp_level(gp_level),
		.count_low_read(count_low_read), .count_high_read(count_high_read),
		.ready_flag(ready_flag), .div_out(div_out),
		.timeout_active(timeout_active),
		.general_output_pins(general_output_pins), .baud_tick(baud_tick),
		.baud_x16(baud_x16));

	// System clock
	always #5 sys_clk = ~sys_clk;

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Expected pin level: divider when routed, plain level otherwise
	function automatic logic exp_pin(input logic route, input logic ctr,
		input logic lvl);
		return route ? ctr : lvl;
	endfunction : exp_pin

	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk);
	endtask : cyc

	// One-cycle start or stop strobe
	task automatic cmd(input logic s, input logic p);
		// Idle edge first, so back to back strobes never collide
		cyc(1);
		start_cmd = s;
		stop_cmd = p;
		cyc(1);
		start_cmd = 1'b0;
		stop_cmd = 1'b0;
	endtask : cmd

	// Cycles until the divider output reaches a level
	task automatic wait_div(input logic lvl, output int k);
		k = 0;
		while (div_out !== lvl && k < 3000) begin
			cyc(1);
			k++;
		end
	endtask : wait_div

	task automatic wait_tick(input int i, output int k);
		k = 0;
		do begin
			cyc(1);
			k++;
		end while (baud_tick[i] !== 1'b1 && k < 3000);
	endtask : wait_tick

	task automatic chan_cmd(input int ch, input logic [3:0] code);
		if (ch == 0) command_reg_chan_a = {1'b1, code};
		else command_reg_chan_b = {1'b1, code};
		cyc(1);
		command_reg_chan_a = 5'h00;
		command_reg_chan_b = 5'h00;
	endtask : chan_cmd

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	// Watchdog
	initial begin
		#300000;
		mismatches++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		void'($urandom(20));
		cyc(4);
		rst = 1'b0;
		cyc(1);
		// Counter mode from the oscillator: corner and random divisors
		for (int i = 0; i < 4; i++) begin
			d = (i == 0) ? 16'h0001 : (i == 1) ? 16'h0100 : 16'($urandom_range(40, 2));
			{divisor_high_reg, divisor_low_reg} = d;
			cmd(1'b1, 1'b0);
			check("load", cnt, d);
			check("out_high", div_out, 1'b1);
			wait_div(1'b0, n);
			check("ready", ready_flag, 1'b1);
			check("zero", cnt, 16'h0000);
			n = 0;
			while (cnt === 16'h0000 && n < 100) begin
				cyc(1);
				n++;
			end
			check("wrap", cnt, 16'hffff);
			cmd(1'b0, 1'b1);
			check("stop", ready_flag, 1'b0);
		end
		// Timer mode; counts not read while the wave runs
		aux_control_reg = 3'h6;
		d = 16'($urandom_range(12, 3));
		{divisor_high_reg, divisor_low_reg} = d;
		cmd(1'b1, 1'b0);
		// First half after start is partial; measure from a toggle
		wait_div(1'b1, n);
		wait_div(1'b0, n);
		check("high_half", 16'(n), d * 16'h0008);
		check("t_ready", ready_flag, 1'b1);
		wait_div(1'b1, n);
		check("low_half", 16'(n), d * 16'h0008);
		wait_div(1'b0, n);
		cmd(1'b0, 1'b1);
		check("t_stop", ready_flag, 1'b0);
		wait_div(1'b1, n);
		wait_div(1'b0, n);
		check("reload", 16'(n), d * 16'h0008);
		check("t_again", ready_flag, 1'b1);
		// Selectors: generator, divider, external 16x and 1x
		clock_select_reg = {bct_pkg::BCT_SEL_EXT1, 4'h0,
			bct_pkg::BCT_SEL_EXT16, 4'h0, bct_pkg::BCT_SEL_DIV, 4'h0,
			bct_pkg::BCT_SEL_GEN, 4'hd};
		extended_mode_reg_chan_a = 3'h1;
		wait_tick(0, n);
		wait_tick(0, n);
		check("gen_period", 16'(n), 16'h0010);
		wait_tick(1, n);
		check("div_tick", 16'(n < 3000), 16'h0001);
		check("x16", baud_x16, 16'h0007);
		extended_mode_reg_chan_a = 3'h0;
		cyc(4);
		n = 0;
		for (int i = 0; i < 100; i++) begin
			cyc(1);
			n += baud_tick[0];
		end
		check("ext_off", 16'(n), 16'h0000);
		// Random pin routing and external clocks
		for (int i = 0; i < 200; i++) begin
			ct_on_pin = 1'($urandom);
			gp_level = 1'($urandom);
			ext_timing_in = 4'($urandom);
			ctr_ext_in = 1'($urandom);
			pre = exp_pin(ct_on_pin, div_out, gp_level);
			cyc(1);
			check("pin", general_output_pins, pre);
		end
		// Counter clocked from the external pin, three rising edges
		aux_control_reg = 3'h0;
		ctr_ext_in = 1'b0;
		{divisor_high_reg, divisor_low_reg} = 16'h0003;
		cmd(1'b0, 1'b1);
		cmd(1'b1, 1'b0);
		for (int i = 0; i < 3; i++) begin
			ctr_ext_in = 1'b1;
			cyc(6);
			ctr_ext_in = 1'b0;
			cyc(6);
		end
		check("ext_zero", cnt, 16'h0000);
		check("ext_ready", ready_flag, 1'b1);
		// Time-out mode on each channel
		aux_control_reg = 3'h2;
		{divisor_high_reg, divisor_low_reg} = 16'h0005;
		for (int ch = 0; ch < 2; ch++) begin
			chan_cmd(ch, 4'ha);
			cyc(1);
			check("to_on", timeout_active, 1'b1);
			check("to_clr", ready_flag, 1'b0);
			{rx_char_b, rx_char_a} = (ch == 0) ? 2'h1 : 2'h2;
			cyc(1);
			{rx_char_b, rx_char_a} = 2'h0;
			check("to_run", div_out, 1'b1);
			wait_div(1'b0, n);
			check("to_ready", ready_flag, 1'b1);
			cmd(1'b1, 1'b0);
			check("to_start", cnt, 16'h0000);
			chan_cmd(ch, 4'hc);
			cyc(1);
			check("to_off", timeout_active, 1'b0);
		end
		tally_and_finish();
	end
endmodule : testbench
